// ===== hw/mrrm_round_stage.sv
// Accumulator result rounding stage with biased-rounding mode select
// How it works
// - Select bit clear gives unbiased rounding
// - Select bit set gives biased rounding
// - Biased: midpoint low word always rounds up
// - Unbiased: midpoint increments only odd middle word
// - Modes differ only at exact midpoint
// - Select is bit twelve of autobuffer control
`timescale 1ns/1ps
`default_nettype none
`include "mrrm_consts.svh"
module mrrm_round_stage (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // Serial port zero autobuffer control write
  input  wire logic              ctrlWrEn,
  input  wire logic [15:0]       ctrlWrData,
  output logic [15:0]            ctrlRdData,
  // Round operation request
  input  wire mrrm_pkg::mrrm_req_t roundReq,
  // Rounded result
  output logic                   resultValid,
  output mrrm_pkg::mrrm_acc_t    accumulatorResult,
  output logic                   roundingBiasSelect
);
  ////////////////////////////////////////////////////////////////////////
  logic [15:0]          ctrl_r, ctrl_nxt;
  logic                 valid_r, valid_nxt;
  mrrm_pkg::mrrm_acc_t  res_r, res_nxt;
  logic [39:0]          rounded;

  mrrm_rounder u_mrrm_rounder (
    .accIn   (roundReq.acc),
    .biasSel (ctrl_r[`MRRM_BIAS_BIT]),
    .accOut  (rounded)
  );

  always_comb begin
    ctrl_nxt = ctrl_r;
    if (ctrlWrEn) begin
      ctrl_nxt = ctrlWrData;
    end
    valid_nxt = roundReq.valid;
    res_nxt   = res_r;
    if (roundReq.valid) begin
      res_nxt = rounded;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r  <= `MRRM_CTRL_RESET;
      valid_r <= 1'b0;
      res_r   <= '0;
    end else begin
      ctrl_r  <= ctrl_nxt;
      valid_r <= valid_nxt;
      res_r   <= res_nxt;
    end
  end

  assign ctrlRdData         = ctrl_r;
  assign resultValid        = valid_r;
  assign accumulatorResult  = res_r;
  assign roundingBiasSelect = ctrl_r[`MRRM_BIAS_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Reset leaves unbiased mode and no pending result
  property p_reset_clear;
    @(posedge clk)
    !resetn |=> (ctrlRdData == `MRRM_CTRL_RESET && !resultValid && accumulatorResult == '0);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("Reset did not clear the stage");

  property p_valid;
    @(posedge clk) disable iff (!resetn)
    roundReq.valid |=> resultValid ##1 (resultValid == $past(roundReq.valid));
  endproperty
  a_valid: assert property (p_valid)
    else $error("Result valid timing wrong");

  property p_valid_idle;
    @(posedge clk) disable iff (!resetn)
    !roundReq.valid |=> !resultValid;
  endproperty
  a_valid_idle: assert property (p_valid_idle)
    else $error("Result valid without request");

  property p_hold;
    @(posedge clk) disable iff (!resetn)
    !roundReq.valid |=> $stable(res_r);
  endproperty
  a_hold: assert property (p_hold)
    else $error("Result changed without request");

  // Control word changes only on a write, and keeps all sixteen bits
  property p_ctrl_write;
    @(posedge clk) disable iff (!resetn)
    ctrlWrEn |=> (roundingBiasSelect == $past(ctrlWrData[`MRRM_BIAS_BIT]));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("Bias select not taken from bit twelve");

  property p_ctrl_word;
    @(posedge clk) disable iff (!resetn)
    ctrlWrEn |=> (ctrlRdData == $past(ctrlWrData));
  endproperty
  a_ctrl_word: assert property (p_ctrl_word)
    else $error("Control word not stored whole");

  property p_ctrl_hold;
    @(posedge clk) disable iff (!resetn)
    !ctrlWrEn |=> $stable(ctrlRdData);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold)
    else $error("Control word changed without write");

  // Mode is the registered bit, so a write in the request cycle is too late
  property p_mode_from_reg;
    @(posedge clk) disable iff (!resetn)
    (roundReq.valid && ctrlWrEn && !ctrl_r[`MRRM_BIAS_BIT] && ctrlWrData[`MRRM_BIAS_BIT] &&
     roundReq.acc.low == `MRRM_MIDPOINT && !roundReq.acc.middle[0])
      |=> !res_r.middle[0];
  endproperty
  a_mode_from_reg: assert property (p_mode_from_reg)
    else $error("Same-cycle write changed the rounding mode");

  // Unbiased midpoint rounds half to even on the middle word
  property p_unbiased_mid;
    @(posedge clk) disable iff (!resetn)
    (roundReq.valid && !ctrl_r[`MRRM_BIAS_BIT] && roundReq.acc.low == `MRRM_MIDPOINT)
      |=> (res_r[39:16] == {$past(roundReq.acc[39:17]), 1'b0} +
           ($past(roundReq.acc.middle[0]) ? 24'h000002 : 24'h000000));
  endproperty
  a_unbiased_mid: assert property (p_unbiased_mid)
    else $error("Unbiased midpoint result wrong");

  property p_unbiased_even;
    @(posedge clk) disable iff (!resetn)
    (roundReq.valid && !ctrl_r[`MRRM_BIAS_BIT] && roundReq.acc.low == `MRRM_MIDPOINT &&
     !roundReq.acc.middle[0])
      |=> (res_r[39:16] == $past(roundReq.acc[39:16]));
  endproperty
  a_unbiased_even: assert property (p_unbiased_even)
    else $error("Unbiased even midpoint was rounded up");

  property p_unbiased_odd;
    @(posedge clk) disable iff (!resetn)
    (roundReq.valid && !ctrl_r[`MRRM_BIAS_BIT] && roundReq.acc.low == `MRRM_MIDPOINT &&
     roundReq.acc.middle[0])
      |=> (res_r[39:16] == $past(roundReq.acc[39:16]) + 24'h000001);
  endproperty
  a_unbiased_odd: assert property (p_unbiased_odd)
    else $error("Unbiased odd midpoint not rounded up");

  property p_mode_off;
    @(posedge clk) disable iff (!resetn)
    (roundReq.valid && !ctrl_r[`MRRM_BIAS_BIT])
      |=> (!res_r.middle[0] || $past(roundReq.acc.low) != `MRRM_MIDPOINT);
  endproperty
  a_mode_off: assert property (p_mode_off)
    else $error("Unbiased midpoint left odd middle word");

  // Biased midpoint always rounds up
  property p_biased_mid;
    @(posedge clk) disable iff (!resetn)
    (roundReq.valid && ctrl_r[`MRRM_BIAS_BIT] && roundReq.acc.low == `MRRM_MIDPOINT)
      |=> (res_r[39:16] == $past(roundReq.acc[39:16]) + 24'h000001);
  endproperty
  a_biased_mid: assert property (p_biased_mid)
    else $error("Biased midpoint did not round up");

  property p_mode_on;
    @(posedge clk) disable iff (!resetn)
    (roundReq.valid && ctrl_r[`MRRM_BIAS_BIT] && !roundReq.acc.middle[0] &&
     roundReq.acc.low == `MRRM_MIDPOINT)
      |=> res_r.middle[0];
  endproperty
  a_mode_on: assert property (p_mode_on)
    else $error("Biased even midpoint not rounded up");

  // Away from the midpoint the mode has no effect
  property p_not_mid;
    @(posedge clk) disable iff (!resetn)
    (roundReq.valid && roundReq.acc.low != `MRRM_MIDPOINT)
      |=> (res_r == $past(roundReq.acc) + `MRRM_HALF_LSB);
  endproperty
  a_not_mid: assert property (p_not_mid)
    else $error("Non-midpoint rounding differs from plain add");

  property p_below_mid;
    @(posedge clk) disable iff (!resetn)
    (roundReq.valid && roundReq.acc.low < `MRRM_MIDPOINT)
      |=> (res_r[39:16] == $past(roundReq.acc[39:16]));
  endproperty
  a_below_mid: assert property (p_below_mid)
    else $error("Low word below half was rounded up");

  property p_above_mid;
    @(posedge clk) disable iff (!resetn)
    (roundReq.valid && roundReq.acc.low > `MRRM_MIDPOINT)
      |=> (res_r[39:16] == $past(roundReq.acc[39:16]) + 24'h000001);
  endproperty
  a_above_mid: assert property (p_above_mid)
    else $error("Low word above half not rounded up");

  // Low word keeps the added half, so a midpoint leaves zero there
  property p_low_kept;
    @(posedge clk) disable iff (!resetn)
    roundReq.valid |=> (res_r.low == $past(roundReq.acc.low) + `MRRM_MIDPOINT);
  endproperty
  a_low_kept: assert property (p_low_kept)
    else $error("Low word of result wrong");

  property p_mid_low_zero;
    @(posedge clk) disable iff (!resetn)
    (roundReq.valid && roundReq.acc.low == `MRRM_MIDPOINT)
      |=> (res_r.low == 16'h0000);
  endproperty
  a_mid_low_zero: assert property (p_mid_low_zero)
    else $error("Midpoint left a nonzero low word");
endmodule : mrrm_round_stage
`default_nettype wire

// ===== hw/mrrm_consts.svh
// Constants for the accumulator result rounding stage
`ifndef MRRM_CONSTS_SVH
`define MRRM_CONSTS_SVH
`define MRRM_ACC_W        40
`define MRRM_WORD_W       16
`define MRRM_MIDPOINT     16'h8000
`define MRRM_HALF_LSB     40'h00_0000_8000
`define MRRM_BIAS_BIT     12
`define MRRM_CTRL_RESET   16'h0000
`endif

// ===== hw/mrrm_pkg.sv
// Types for the accumulator result rounding stage
`default_nettype none
package mrrm_pkg;
  typedef struct packed {
    logic [7:0]  upper;
    logic [15:0] middle;
    logic [15:0] low;
  } mrrm_acc_t;

  typedef struct packed {
    logic      valid;
    mrrm_acc_t acc;
  } mrrm_req_t;
endpackage : mrrm_pkg
`default_nettype wire

// ===== hw/mrrm_rounder.sv
// Combinational rounding of a 40-bit accumulator result
`timescale 1ns/1ps
`default_nettype none
`include "mrrm_consts.svh"
module mrrm_rounder (
  // Operand and mode
  input  wire logic [39:0] accIn,
  input  wire logic        biasSel,
  // Rounded value
  output logic [39:0]      accOut
);
  logic [39:0] sum;
  logic        isMid;

  always_comb begin
    sum   = accIn + `MRRM_HALF_LSB;
    isMid = (accIn[15:0] == `MRRM_MIDPOINT);
    accOut = sum;
    // Clearing the LSB gives round-half-even; other low words untouched
    if (isMid && !biasSel) begin
      accOut[16] = 1'b0;
    end
    // Biased mode keeps the carry: midpoint always rounds up
  end
endmodule : mrrm_rounder
`default_nettype wire

// ===== verif/mrrm_round_stage_test.sv
// Self-checking bench for the accumulator rounding stage
`timescale 1ns/1ps
`default_nettype none
module mrrm_round_stage_test;
  logic                clk = 1'b0;
  logic                resetn = 1'b0;
  logic                ctrlWrEn = 1'b0;
  logic [15:0]         ctrlWrData = 16'h0000;
  logic [15:0]         ctrlRdData;
  mrrm_pkg::mrrm_req_t roundReq = '0;
  logic                resultValid;
  mrrm_pkg::mrrm_acc_t accumulatorResult;
  logic                roundingBiasSelect;
  int                  fails = 0;
  int                  numChecks = 0;
  always #4 clk = ~clk;
  mrrm_round_stage u_mrrm_round_stage (.clk(clk), .resetn(resetn), .ctrlWrEn(ctrlWrEn),
    .ctrlWrData(ctrlWrData), .ctrlRdData(ctrlRdData), .roundReq(roundReq),
    .resultValid(resultValid), .accumulatorResult(accumulatorResult),
    .roundingBiasSelect(roundingBiasSelect));
  task automatic chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
    numChecks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [15:0] d);
    @(negedge clk);
    ctrlWrEn = 1'b1;
    ctrlWrData = d;
    @(negedge clk);
    ctrlWrEn = 1'b0;
    chk("ctrlRdData", {24'h00_0000, ctrlRdData}, {24'h00_0000, d});
    chk("roundingBiasSelect", {39'h0, roundingBiasSelect}, {39'h0, d[12]});
  endtask : wr
  // One request, then an idle cycle; e is the whole expected 40-bit word
  task automatic roundOnce(input logic [39:0] a, input logic [39:0] e);
    @(negedge clk);
    roundReq = {1'b1, a};
    @(negedge clk);
    roundReq.valid = 1'b0;
    chk("resultValid", {39'h0, resultValid}, 40'h00_0000_0001);
    chk("result", accumulatorResult, e);
  endtask : roundOnce
  //////////////////////////////////////////////////////////////////////////////
  task automatic testReset();
    chk("rstCtrl", {24'h00_0000, ctrlRdData}, 40'h00_0000_0000);
    chk("rstValid", {39'h0, resultValid}, 40'h00_0000_0000);
    chk("rstResult", accumulatorResult, 40'h00_0000_0000);
  endtask : testReset
  task automatic testMode(input logic b);
    logic [39:0] inp [9];
    logic [39:0] expB [9];
    logic [39:0] expU [9];
    inp  = '{40'h00_0000_8000, 40'h00_0001_8000, 40'h00_0000_8001, 40'h00_0001_8001,
             40'h00_0000_7fff, 40'h00_0001_7fff, 40'hff_ffff_8000, 40'h12_3456_8000,
             40'h00_ffff_8001};
    expB = '{40'h00_0001_0000, 40'h00_0002_0000, 40'h00_0001_0001, 40'h00_0002_0001,
             40'h00_0000_ffff, 40'h00_0001_ffff, 40'h00_0000_0000, 40'h12_3457_0000,
             40'h01_0000_0001};
    expU = '{40'h00_0000_0000, 40'h00_0002_0000, 40'h00_0001_0001, 40'h00_0002_0001,
             40'h00_0000_ffff, 40'h00_0001_ffff, 40'h00_0000_0000, 40'h12_3456_0000,
             40'h01_0000_0001};
    wr({3'h0, b, 12'h000});
    foreach (inp[i]) begin
      roundOnce(inp[i], b ? expB[i] : expU[i]);
    end
    @(negedge clk);
    chk("validPulse", {39'h0, resultValid}, 40'h00_0000_0000);
    chk("resultHeld", accumulatorResult, 40'h01_0000_0001);
  endtask : testMode
  task automatic testCtrlBits();
    wr(16'hefff);
    roundOnce(40'h00_0002_8000, 40'h00_0002_0000);
    wr(16'h1000);
    roundOnce(40'h00_0002_8000, 40'h00_0003_0000);
  endtask : testCtrlBits
  // Write with a request uses the old mode; the next request, back to back, the new
  task automatic testSameCycle();
    wr(16'h0000);
    @(negedge clk);
    ctrlWrEn = 1'b1;
    ctrlWrData = 16'h1000;
    roundReq = {1'b1, 40'h00_0000_8000};
    @(negedge clk);
    ctrlWrEn = 1'b0;
    roundReq = {1'b1, 40'h00_0004_8000};
    chk("sameValid", {39'h0, resultValid}, 40'h00_0000_0001);
    chk("oldMode", accumulatorResult, 40'h00_0000_0000);
    chk("newBit", {39'h0, roundingBiasSelect}, 40'h00_0000_0001);
    @(negedge clk);
    roundReq.valid = 1'b0;
    chk("backToBack", {39'h0, resultValid}, 40'h00_0000_0001);
    chk("newMode", accumulatorResult, 40'h00_0005_0000);
  endtask : testSameCycle
  task automatic testMidReset();
    @(negedge clk);
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    chk("midCtrl", {24'h00_0000, ctrlRdData}, 40'h00_0000_0000);
    chk("midValid", {39'h0, resultValid}, 40'h00_0000_0000);
    chk("midResult", accumulatorResult, 40'h00_0000_0000);
    resetn = 1'b1;
    roundOnce(40'h00_0002_8000, 40'h00_0002_0000);
  endtask : testMidReset
  task automatic completeRun();
    $display("checks %0d mismatches %0d", numChecks, fails);
    if (fails == 0 && numChecks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : completeRun
  initial begin
    #5000;
    fails++;
    completeRun();
  end
  initial begin
    repeat (4) @(negedge clk);
    testReset();
    resetn = 1'b1;
    testMode(1'b0);
    testMode(1'b1);
    testCtrlBits();
    testSameCycle();
    testMidReset();
    completeRun();
  end
endmodule : mrrm_round_stage_test
`default_nettype wire
